// ==== inc/trib_pkg.sv ====
// Purpose: Shared constants and carriers for the tributary command handler
// Assumes: Request keys are octal codes as seen by the host
// Notes: Octal 20 and 21 are 8'h10 and 8'h11
package trib_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SLOTS = 12;
  localparam logic [7:0] KEY_NOP = 8'h00;
  localparam logic [7:0] KEY_ESTABLISH = 8'h01;
  localparam logic [7:0] KEY_DELETE = 8'h02;
  localparam logic [7:0] KEY_STARTUP = 8'h03;
  localparam logic [7:0] KEY_MAINT = 8'h04;
  localparam logic [7:0] KEY_HALT = 8'h05;
  localparam logic [7:0] KEY_MODEM_SET = 8'h10;
  localparam logic [7:0] KEY_MODEM_GET = 8'h11;
  localparam logic [7:0] ERR_POOL_BUSY = 8'h88;
  localparam logic [7:0] ERR_BAD_STATE = 8'h89;
  localparam logic [7:0] ERR_NO_SLOT = 8'h8A;
  localparam logic [7:0] MODEM_RESET = 8'h00;
  localparam logic [3:0] STARTUP_CYCLES = 4'h8;

  typedef enum logic [1:0] {ST_HALT, ST_STARTING, ST_RUN, ST_MAINT} trib_state_e;

  typedef struct packed {
    logic [7:0] key;
    logic [7:0] tributary_address_byte;
    logic [7:0] modem_data_byte;
    logic [7:0] command_option_byte;
  } command_s;

  typedef enum logic [1:0] {RSP_NONE, RSP_CONTROL, RSP_INFO, RSP_ERROR} resp_kind_e;

  typedef struct packed {
    resp_kind_e kind;
    logic [7:0] address;
    logic [7:0] code;
    logic [7:0] response_word_four;
  } response_s;
endpackage

// ==== logic/trib_cmd.sv ====
// Purpose: Interprets control command request keys for up to twelve tributaries
// Assumes: Host raises cmd_valid for one cycle with the command fields stable
// Notes: Start-up handshake with the far station is modelled by a fixed delay
//
// How it works
// - Key 02 discards the addressed tributary status slot.
// - A deleted slot returns only through an establish command.
// - At most twelve addresses are established at once.
// - Key 03 initialises the slot and begins link start-up.
// - Finished start-up posts a run-state control response unless a host command answers in the same cycle.
// - Key 04 puts the tributary into maintenance state.
// - In maintenance only maintenance messages pass for that tributary.
// - Maintenance traffic needs both ends in maintenance state.
// - Key 05 halts the tributary and returns its outstanding buffers.
// - A halted tributary at the control station is not polled.
// - A halted tributary station stops answering polls.
// - Halting leaves the status slot intact for later restart.
// - Halt with address zero returns every common-pool buffer.
// - Global halt with the pool busy reports procedural error 136.
// - Code 20 writes the modem-data byte into the modem register.
// - Code 21 returns the modem register in response word four.
// - Key 01 creates a status slot for the given address.
`timescale 1ns/1ps
module trib_cmd #(
  parameter int unsigned NSLOT = trib_pkg::SLOTS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Host command
  input wire logic cmd_valid,
  input wire trib_pkg::command_s cmd,
  // Station role and link status
  input wire logic is_control_station,
  input wire logic pool_in_use,
  input wire logic far_end_maint,
  input wire logic [7:0] poll_address,
  // Responses
  output trib_pkg::response_s resp,
  output logic resp_valid,
  // Buffer return
  output logic return_buffers,
  output logic [7:0] return_address,
  output logic return_pool,
  // Link control
  output logic poll_enable,
  output logic answer_poll,
  output logic data_allowed,
  output logic maint_allowed,
  output logic [7:0] modem_reg
);
  logic [NSLOT-1:0] used_r, used_nxt;
  logic [7:0] addr_r [NSLOT];
  logic [7:0] addr_nxt [NSLOT];
  trib_pkg::trib_state_e st_r [NSLOT];
  trib_pkg::trib_state_e st_nxt [NSLOT];
  logic [3:0] tmr_r [NSLOT];
  logic [3:0] tmr_nxt [NSLOT];
  trib_pkg::response_s resp_r, resp_nxt;
  logic resp_valid_r, resp_valid_nxt;
  logic ret_r, ret_nxt, pool_r, pool_nxt;
  logic [7:0] ret_addr_r, ret_addr_nxt, modem_r, modem_nxt;

  function automatic int find_slot(input logic [NSLOT-1:0] used, input logic [7:0] a,
                                   input logic [7:0] tbl [NSLOT]);
    int hit;
    hit = -1;
    for (int i = 0; i < NSLOT; i++)
    begin
      if (used[i] && tbl[i] == a && hit < 0)
        hit = i;
    end
    return hit;
  endfunction

  function automatic int find_free(input logic [NSLOT-1:0] used);
    int hit;
    hit = -1;
    for (int i = NSLOT - 1; i >= 0; i--)
    begin
      if (!used[i])
        hit = i;
    end
    return hit;
  endfunction

  int hit, cmd_hit, poll_hit, freeslot;
  logic [7:0] a;

  always_comb
  begin
    used_nxt = used_r;
    addr_nxt = addr_r;
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    resp_nxt = resp_r;
    resp_valid_nxt = 1'b0;
    ret_nxt = 1'b0;
    pool_nxt = 1'b0;
    ret_addr_nxt = ret_addr_r;
    modem_nxt = modem_r;
    hit = -1;
    freeslot = -1;
    a = cmd.tributary_address_byte;
    // Start-up completion posts the run response
    for (int i = 0; i < NSLOT; i++)
    begin
      if (used_r[i] && st_r[i] == trib_pkg::ST_STARTING)
      begin
        if (tmr_r[i] == 4'h1)
        begin
          st_nxt[i] = trib_pkg::ST_RUN;
          resp_valid_nxt = 1'b1;
          resp_nxt = '{trib_pkg::RSP_CONTROL, addr_r[i], 8'h00, 8'h00};
        end
        tmr_nxt[i] = tmr_r[i] - 4'h1;
      end
    end
    // A host command that answers takes the response slot over a completion in the same cycle
    if (cmd_valid)
    begin
      hit = find_slot(used_r, a, addr_r);
      freeslot = find_free(used_r);
      unique case (cmd.key)
        trib_pkg::KEY_ESTABLISH:
        begin
          if (hit < 0 && freeslot >= 0)
          begin
            used_nxt[freeslot] = 1'b1;
            addr_nxt[freeslot] = a;
            st_nxt[freeslot] = trib_pkg::ST_HALT;
            tmr_nxt[freeslot] = 4'h0;
          end
          else if (hit < 0)
          begin
            resp_valid_nxt = 1'b1;
            resp_nxt = '{trib_pkg::RSP_ERROR, a, trib_pkg::ERR_NO_SLOT, 8'h00};
          end
        end
        trib_pkg::KEY_DELETE, trib_pkg::KEY_STARTUP, trib_pkg::KEY_MAINT:
        begin
          if (hit < 0 || st_r[hit] != trib_pkg::ST_HALT)
          begin
            resp_valid_nxt = 1'b1;
            resp_nxt = '{trib_pkg::RSP_ERROR, a, trib_pkg::ERR_BAD_STATE, 8'h00};
          end
          else if (cmd.key == trib_pkg::KEY_DELETE)
          begin
            // discard slot; only establish recreates it
            used_nxt[hit] = 1'b0;
          end
          else if (cmd.key == trib_pkg::KEY_STARTUP)
          begin
            st_nxt[hit] = trib_pkg::ST_STARTING;
            tmr_nxt[hit] = trib_pkg::STARTUP_CYCLES;
          end
          else
          begin
            st_nxt[hit] = trib_pkg::ST_MAINT;
          end
        end
        trib_pkg::KEY_HALT:
        begin
          if (a == 8'h00)
          begin
            if (pool_in_use)
            begin
              resp_valid_nxt = 1'b1;
              resp_nxt = '{trib_pkg::RSP_ERROR, a, trib_pkg::ERR_POOL_BUSY, 8'h00};
            end
            else
            begin
              pool_nxt = 1'b1;
            end
          end
          else if (hit >= 0)
          begin
            // halt and return buffers; slot kept
            st_nxt[hit] = trib_pkg::ST_HALT;
            tmr_nxt[hit] = 4'h0;
            ret_nxt = 1'b1;
            ret_addr_nxt = a;
          end
          else
          begin
            resp_valid_nxt = 1'b1;
            resp_nxt = '{trib_pkg::RSP_ERROR, a, trib_pkg::ERR_BAD_STATE, 8'h00};
          end
        end
        trib_pkg::KEY_MODEM_SET:
          modem_nxt = cmd.modem_data_byte;
        trib_pkg::KEY_MODEM_GET:
        begin
          resp_valid_nxt = 1'b1;
          resp_nxt = '{trib_pkg::RSP_INFO, a, 8'h00, modem_r};
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      used_r <= '0;
      for (int i = 0; i < NSLOT; i++)
      begin
        addr_r[i] <= 8'h00;
        st_r[i] <= trib_pkg::ST_HALT;
        tmr_r[i] <= 4'h0;
      end
      resp_r <= '{trib_pkg::RSP_NONE, 8'h00, 8'h00, 8'h00};
      resp_valid_r <= 1'b0;
      ret_r <= 1'b0;
      pool_r <= 1'b0;
      ret_addr_r <= 8'h00;
      modem_r <= trib_pkg::MODEM_RESET;
    end
    else
    begin
      used_r <= used_nxt;
      addr_r <= addr_nxt;
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      resp_r <= resp_nxt;
      resp_valid_r <= resp_valid_nxt;
      ret_r <= ret_nxt;
      pool_r <= pool_nxt;
      ret_addr_r <= ret_addr_nxt;
      modem_r <= modem_nxt;
    end
  end

  // Link gating for the tributary currently offered by the poller
  always_comb
  begin
    poll_hit = find_slot(used_r, poll_address, addr_r);
    cmd_hit = poll_hit;
    poll_enable = is_control_station && poll_hit >= 0 && st_r[poll_hit] != trib_pkg::ST_HALT;
    answer_poll = !is_control_station && poll_hit >= 0 && st_r[poll_hit] != trib_pkg::ST_HALT;
    maint_allowed = cmd_hit >= 0 && st_r[cmd_hit] == trib_pkg::ST_MAINT && far_end_maint;
    data_allowed = cmd_hit >= 0 && st_r[cmd_hit] == trib_pkg::ST_RUN;
  end

  assign resp = resp_r;
  assign resp_valid = resp_valid_r;
  assign return_buffers = ret_r;
  assign return_address = ret_addr_r;
  assign return_pool = pool_r;
  assign modem_reg = modem_r;

  sequence pool_busy_halt_s;
    cmd_valid && cmd.key == trib_pkg::KEY_HALT && cmd.tributary_address_byte == 8'h00 && pool_in_use;
  endsequence

  // Error 136 on busy pool
  pool_error_a: assert property (@(posedge clock) disable iff (rst)
    pool_busy_halt_s |=> resp_valid && resp.code == trib_pkg::ERR_POOL_BUSY && !return_pool)
    else $error("busy pool halt not flagged");
  // Global halt returns pool
  pool_return_a: assert property (@(posedge clock) disable iff (rst)
    cmd_valid && cmd.key == trib_pkg::KEY_HALT && cmd.tributary_address_byte == 8'h00 && !pool_in_use
    |=> return_pool)
    else $error("pool not returned");
  // Modem write
  modem_write_a: assert property (@(posedge clock) disable iff (rst)
    cmd_valid && cmd.key == trib_pkg::KEY_MODEM_SET |=> modem_reg == $past(cmd.modem_data_byte))
    else $error("modem register not written");
  // Modem read
  modem_read_a: assert property (@(posedge clock) disable iff (rst)
    cmd_valid && cmd.key == trib_pkg::KEY_MODEM_GET
    |=> resp_valid && resp.kind == trib_pkg::RSP_INFO && resp.response_word_four == $past(modem_reg))
    else $error("modem read response wrong");
  // Modem stable otherwise
  modem_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(cmd_valid && cmd.key == trib_pkg::KEY_MODEM_SET) |=> $stable(modem_reg))
    else $error("modem register changed");
  // Buffer return only after a halt
  halt_return_a: assert property (@(posedge clock) disable iff (rst)
    return_buffers |-> return_address != 8'h00 && $past(cmd_valid) && $past(cmd.key) == trib_pkg::KEY_HALT)
    else $error("buffer return without halt");
  // New address with every slot taken
  slot_limit_a: assert property (@(posedge clock) disable iff (rst)
    cmd_valid && cmd.key == trib_pkg::KEY_ESTABLISH && hit < 0 && &used_r
    |=> resp_valid && resp.code == trib_pkg::ERR_NO_SLOT && $stable(used_r))
    else $error("slot limit not enforced");
  // Maintenance gating
  maint_gate_a: assert property (@(posedge clock) disable iff (rst)
    maint_allowed |-> far_end_maint && !data_allowed)
    else $error("maintenance traffic misgated");
  // Halted tributary not polled
  halt_poll_a: assert property (@(posedge clock) disable iff (rst)
    cmd_valid && cmd.key == trib_pkg::KEY_HALT && cmd.tributary_address_byte != 8'h00
    && cmd.tributary_address_byte == poll_address
    |=> !poll_enable || !$stable(poll_address))
    else $error("halted tributary still polled");
endmodule

// ==== tb/tb_trib_cmd.sv ====
// Purpose: Self-checking bench for the tributary command handler
// Assumes: Answers land at the taking edge, run response STARTUP_CYCLES after it
// Notes: Inputs move at the rising edge by non-blocking assignment, outputs are read 1 ns later
`timescale 1ns/1ps
module tb_trib_cmd;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  trib_pkg::command_s cmd = '0;
  logic is_control_station = 1'b1;
  logic pool_in_use = 1'b0;
  logic far_end_maint = 1'b0;
  logic [7:0] poll_address = 8'h03;
  trib_pkg::response_s resp;
  logic resp_valid, return_buffers, return_pool, poll_enable, answer_poll, data_allowed, maint_allowed;
  logic [7:0] return_address, modem_reg;
  int miscompares = 0;
  int checked = 0;

  trib_cmd #(.NSLOT(trib_pkg::SLOTS)) i_trib_cmd (.clock(clock), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .is_control_station(is_control_station), .pool_in_use(pool_in_use), .far_end_maint(far_end_maint),
    .poll_address(poll_address), .resp(resp), .resp_valid(resp_valid), .return_buffers(return_buffers),
    .return_address(return_address), .return_pool(return_pool), .poll_enable(poll_enable),
    .answer_poll(answer_poll), .data_allowed(data_allowed), .maint_allowed(maint_allowed), .modem_reg(modem_reg));

  always #2.5 clock = ~clock;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // One-cycle strobe; returns in the cycle where the answer stands
  task automatic send(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd <= {k, a, d, 8'h00};
    @(posedge clock);
    cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic expect_err(input logic [7:0] code);
    chk_bit("error valid", 1'b1, resp_valid);
    chk("error kind", {6'h00, trib_pkg::RSP_ERROR}, {6'h00, resp.kind});
    chk("error code", code, resp.code);
  endtask

  task automatic no_err(input string what);
    chk_bit(what, 1'b0, resp_valid === 1'b1 && resp.kind === trib_pkg::RSP_ERROR);
  endtask

  task automatic wait_run(input logic [7:0] a);
    int k;
    k = 0;
    while (resp_valid !== 1'b1 && k < 12)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    chk("run delay", {4'h0, trib_pkg::STARTUP_CYCLES}, 8'(k));
    chk("run kind", {6'h00, trib_pkg::RSP_CONTROL}, {6'h00, resp.kind});
    chk("run address", a, resp.address);
  endtask

  task automatic set_input(input int which, input logic v);
    @(posedge clock);
    if (which == 0) is_control_station <= v;
    else if (which == 1) far_end_maint <= v;
    else pool_in_use <= v;
    #1;
  endtask

  task automatic t_reset;
    chk_bit("resp_valid", 1'b0, resp_valid);
    chk("modem_reg", trib_pkg::MODEM_RESET, modem_reg);
    chk_bit("return_pool", 1'b0, return_pool);
    $display("test reset done");
  endtask

  task automatic t_modem;
    send(trib_pkg::KEY_MODEM_SET, 8'h00, 8'hA5);
    chk("modem_reg", 8'hA5, modem_reg);
    send(trib_pkg::KEY_MODEM_GET, 8'h00, 8'h3C);
    chk("info kind", {6'h00, trib_pkg::RSP_INFO}, {6'h00, resp.kind});
    chk("word four", 8'hA5, resp.response_word_four);
    chk("modem_reg kept", 8'hA5, modem_reg);
    $display("test modem done");
  endtask

  task automatic t_life;
    send(trib_pkg::KEY_ESTABLISH, 8'h03, 8'h00);
    send(trib_pkg::KEY_STARTUP, 8'h03, 8'h00);
    wait_run(8'h03);
    chk_bit("data in run", 1'b1, data_allowed);
    chk_bit("poll_enable run", 1'b1, poll_enable);
    set_input(0, 1'b0);
    chk_bit("answer_poll run", 1'b1, answer_poll);
    send(trib_pkg::KEY_HALT, 8'h03, 8'h00);
    chk_bit("return_buffers", 1'b1, return_buffers);
    chk("return_address", 8'h03, return_address);
    chk_bit("answer_poll halt", 1'b0, answer_poll);
    set_input(0, 1'b1);
    chk_bit("poll_enable halt", 1'b0, poll_enable);
    // Restart needs the slot kept by the halt
    send(trib_pkg::KEY_STARTUP, 8'h03, 8'h00);
    wait_run(8'h03);
    send(trib_pkg::KEY_HALT, 8'h03, 8'h00);
    $display("test lifecycle done");
  endtask

  task automatic t_maint;
    send(trib_pkg::KEY_MAINT, 8'h03, 8'h00);
    set_input(1, 1'b1);
    chk_bit("maint both", 1'b1, maint_allowed);
    chk_bit("data in maint", 1'b0, data_allowed);
    set_input(1, 1'b0);
    chk_bit("maint one end", 1'b0, maint_allowed);
    send(trib_pkg::KEY_STARTUP, 8'h03, 8'h00);
    expect_err(trib_pkg::ERR_BAD_STATE);
    send(trib_pkg::KEY_HALT, 8'h03, 8'h00);
    $display("test maintenance done");
  endtask

  task automatic t_delete;
    send(trib_pkg::KEY_STARTUP, 8'h03, 8'h00);
    wait_run(8'h03);
    send(trib_pkg::KEY_DELETE, 8'h03, 8'h00);
    expect_err(trib_pkg::ERR_BAD_STATE);
    send(trib_pkg::KEY_HALT, 8'h03, 8'h00);
    send(trib_pkg::KEY_DELETE, 8'h03, 8'h00);
    no_err("delete halted");
    send(trib_pkg::KEY_STARTUP, 8'h03, 8'h00);
    expect_err(trib_pkg::ERR_BAD_STATE);
    send(trib_pkg::KEY_ESTABLISH, 8'h03, 8'h00);
    send(trib_pkg::KEY_STARTUP, 8'h03, 8'h00);
    wait_run(8'h03);
    send(trib_pkg::KEY_HALT, 8'h03, 8'h00);
    $display("test delete done");
  endtask

  task automatic t_global;
    set_input(2, 1'b1);
    send(trib_pkg::KEY_HALT, 8'h00, 8'h00);
    expect_err(trib_pkg::ERR_POOL_BUSY);
    chk_bit("pool kept", 1'b0, return_pool);
    set_input(2, 1'b0);
    send(trib_pkg::KEY_HALT, 8'h00, 8'h00);
    chk_bit("pool returned", 1'b1, return_pool);
    $display("test global halt done");
  endtask

  task automatic t_limit;
    for (int a = 1; a <= 12; a++)
    begin
      send(trib_pkg::KEY_ESTABLISH, 8'(a), 8'h00);
      no_err("establish within limit");
    end
    send(trib_pkg::KEY_ESTABLISH, 8'h0D, 8'h00);
    expect_err(trib_pkg::ERR_NO_SLOT);
    $display("test slot limit done");
  endtask

  task automatic conclude;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Whole run is about 120 cycles; this leaves wide margin
  initial
  begin
    #20000;
    miscompares++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    #1;
    t_reset();
    t_modem();
    t_life();
    t_maint();
    t_delete();
    t_global();
    t_limit();
    conclude();
  end
endmodule
